/* File: verilog/sacc_defs.vh */
// constants shared by the conversion control block
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// register byte offsets
`define SACC_OFF_CONTROL 8'h00
`define SACC_OFF_CHANNEL 8'h04
`define SACC_OFF_PAIR 8'h08
`define SACC_OFF_CONFIG 8'h0c
`define SACC_OFF_RESULT_HIGH 8'h10
`define SACC_OFF_RESULT_LOW 8'h14

// converter_control_reg fields
`define SACC_CTL_ON 7
`define SACC_CTL_LOW_POWER 6
`define SACC_CTL_DONE 5
`define SACC_CTL_BUSY 4
`define SACC_CTL_SRC_HI 3
`define SACC_CTL_SRC_LO 2
`define SACC_CTL_LEFT_JUSTIFY 0

// converter_config_reg fields
`define SACC_CFG_DIV_HI 7
`define SACC_CFG_DIV_LO 3
`define SACC_CFG_GAIN_HI 2
`define SACC_CFG_GAIN_LO 0

// reset values
`define SACC_RST_CONTROL 8'h00
`define SACC_RST_CHANNEL 4'h0
`define SACC_RST_PAIR 4'h0
`define SACC_RST_CONFIG 8'hf8

// start sources
`define SACC_SRC_SOFTWARE 2'b00
`define SACC_SRC_TIMER3 2'b01
`define SACC_SRC_EXTERNAL 2'b10
`define SACC_SRC_TIMER2 2'b11

// conversion figures
`define SACC_RESOLUTION 12
`define SACC_TRACK_TICKS 2'd3
`define SACC_PCLK_PERIOD_NS 40
`define SACC_MIN_PERIOD_NS 10000
`define SACC_MIN_PERIOD_CYCLES \
    ((`SACC_MIN_PERIOD_NS + `SACC_PCLK_PERIOD_NS - 1) / `SACC_PCLK_PERIOD_NS)

`endif

/* File: verilog/sacc_clock_divider.v */
// conversion clock enable generator
`timescale 1ns/1ps
`include "sacc_defs.vh"

module sacc_clock_divider (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire restart,
    input wire [4:0] divider,
    output wire tick
);

reg [5:0] count;
wire [5:0] last;

// period is 2*(divider+1) clocks, or one clock for a zero divider
assign last = (divider == 5'h00) ? 6'h00 : {divider, 1'b1};
assign tick = !restart && (count == last);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        count <= 6'h00;
    else if (clk_en)
    begin
        if (restart || count >= last)
            count <= 6'h00;
        else
            count <= count + 6'h01;
    end
end

endmodule // sacc_clock_divider

/* File: verilog/sacc_sar_register.v */
// successive approximation register
`timescale 1ns/1ps
`include "sacc_defs.vh"

module sacc_sar_register (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire load,
    input wire step,
    input wire comparator_high,
    output reg [`SACC_RESOLUTION-1:0] trial,
    output wire [`SACC_RESOLUTION-1:0] decided,
    output wire finish
);

reg [`SACC_RESOLUTION-1:0] mask;

// keep the bit under test when the input is at or above the trial level
assign decided = comparator_high ? trial : (trial & ~mask);
assign finish = step && mask[0];

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        trial <= 12'h000;
        mask <= 12'h000;
    end
    else if (clk_en)
    begin
        if (load)
        begin
            trial <= 12'h800;
            mask <= 12'h800;
        end
        else if (step && (mask != 12'h000))
        begin
            trial <= decided | (mask >> 1);
            mask <= mask >> 1;
        end
    end
end

endmodule // sacc_sar_register

/* File: verilog/sacc_conversion_control.v */
// conversion control with apb registers for the sampling converter
// What this block does
// - converter, track-and-hold and gain stage powered only while converter_on_bit set
// - input selector offers eight external channels plus the temperature sensor
// - each pair is single-ended or differential; all single-ended after reset
// - gain field selects 0.5, 1, 2, 4, 8 or 16
// - gain resets to unity
// - temperature sensor code routes the sensor into the gain stage
// - conversion clock divided from pclk; rate never above 100 ksps
// - four start sources: software busy write, timer 3, pin edge, timer 2
// - busy stays high through a conversion and drops when it ends
// - busy falling at the end of a conversion sets done flag bit 5 and the interrupt request; a shutdown drops busy without setting them
// - result placed left or right justified in high and low bytes
// - normal mode tracks continuously while enabled and not converting
// - low-power mode with internal start tracks three conversion clocks first
// - low-power mode with pin start tracks while pin low, converts on rise
// - tracking shuts down during chip standby or sleep
// - results have 12 bits
// - start source codes: 00 software, 01 timer 3, 10 pin, 11 timer 2
// - conversion clock period is 2*(divider+1) clocks, divider zero gives pclk
// - busy write of 0 does nothing; 1 starts only with source 00
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "sacc_defs.vh"

module sacc_conversion_control (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire timer2_overflow,
    input wire timer3_overflow,
    input wire external_start_pin,
    input wire chip_standby,
    input wire comparator_high,
    output reg converter_on,
    output reg gain_stage_on,
    output reg track_enable,
    output reg [2:0] gain_select,
    output reg [2:0] mux_channel,
    output reg mux_differential,
    output reg mux_temp_sensor,
    output wire [11:0] sar_trial,
    output reg conversion_busy,
    output reg conversion_done_irq
);

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_TRACK = 3'b010;
localparam [2:0] ST_CONVERT = 3'b100;
localparam integer GUARD_SPAN = `SACC_MIN_PERIOD_CYCLES - 1;
localparam [7:0] GUARD_LAST = GUARD_SPAN[7:0];

////////////////////////////////////////////////////////////////////////////////
// register state
reg ctl_low_power;
reg conversion_done_flag;
reg [1:0] start_source;
reg left_justify_bit;
reg [3:0] channel_code_field;
reg [3:0] pair_config;
reg [4:0] clock_divider_field;
reg [11:0] result;
reg [2:0] state;
reg [1:0] track_count;
reg [7:0] guard;
reg start_pin_prev;
wire access;
wire setup;
wire mapped;
wire ctl_write;
wire div_tick;
wire sar_finish;
wire [11:0] sar_decided;
// justified result as a high byte and a low byte
function [15:0] justify;
    input [11:0] value;
    input left;
    justify = left ? {value, 4'h0} : {4'h0, value};
endfunction

////////////////////////////////////////////////////////////////////////////////
// apb slave
assign access = psel && penable;
assign setup = psel && !penable;
assign mapped = (paddr == `SACC_OFF_CONTROL) || (paddr == `SACC_OFF_CHANNEL) ||
    (paddr == `SACC_OFF_PAIR) || (paddr == `SACC_OFF_CONFIG) ||
    (paddr == `SACC_OFF_RESULT_HIGH) || (paddr == `SACC_OFF_RESULT_LOW);
// no wait states while running; a frozen block holds the access
assign pready = clk_en;
assign pslverr = access && !mapped;
assign ctl_write = access && clk_en && pwrite && (paddr == `SACC_OFF_CONTROL);
reg [31:0] next_prdata;
reg [15:0] rd_justified;
always @*
begin
    next_prdata = 32'h0000_0000;
    rd_justified = justify(result, left_justify_bit);
    case (paddr)
        `SACC_OFF_CONTROL:
            next_prdata[7:0] = {converter_on, ctl_low_power, conversion_done_flag,
                conversion_busy, start_source, 1'b0, left_justify_bit};
        `SACC_OFF_CHANNEL:
            next_prdata[3:0] = channel_code_field;
        `SACC_OFF_PAIR:
            next_prdata[3:0] = pair_config;
        `SACC_OFF_CONFIG:
            next_prdata[7:0] = {clock_divider_field, gain_select};
        `SACC_OFF_RESULT_HIGH:
            next_prdata[7:0] = rd_justified[15:8];
        `SACC_OFF_RESULT_LOW:
            next_prdata[7:0] = rd_justified[7:0];
        default:
            next_prdata = 32'h0000_0000;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (clk_en && setup && !pwrite)
        prdata <= next_prdata;
end

// writable configuration
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        converter_on <= 1'b0;
        ctl_low_power <= 1'b0;
        start_source <= `SACC_SRC_SOFTWARE;
        left_justify_bit <= 1'b0;
        channel_code_field <= `SACC_RST_CHANNEL;
        pair_config <= `SACC_RST_PAIR;
        clock_divider_field <= 5'h1f;
        gain_select <= 3'b000;
    end
    else if (clk_en && access && pwrite)
    begin
        case (paddr)
            `SACC_OFF_CONTROL:
            begin
                converter_on <= pwdata[`SACC_CTL_ON];
                ctl_low_power <= pwdata[`SACC_CTL_LOW_POWER];
                start_source <= pwdata[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO];
                left_justify_bit <= pwdata[`SACC_CTL_LEFT_JUSTIFY];
            end
            `SACC_OFF_CHANNEL:
                channel_code_field <= pwdata[3:0];
            `SACC_OFF_PAIR:
                pair_config <= pwdata[3:0];
            `SACC_OFF_CONFIG:
            begin
                clock_divider_field <= pwdata[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
                gain_select <= pwdata[`SACC_CFG_GAIN_HI:`SACC_CFG_GAIN_LO];
            end
            default:
                converter_on <= converter_on;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// start selection
wire start_request;
wire sw_start;
wire pin_rise;
wire start_taken;
// a busy write of zero is ignored; a one counts only with the software source
assign sw_start = ctl_write && pwdata[`SACC_CTL_BUSY] &&
    (pwdata[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO] == `SACC_SRC_SOFTWARE);
assign pin_rise = external_start_pin && !start_pin_prev;
assign start_request = (start_source == `SACC_SRC_SOFTWARE) ? sw_start :
    (start_source == `SACC_SRC_TIMER3) ? timer3_overflow :
    (start_source == `SACC_SRC_EXTERNAL) ? pin_rise : timer2_overflow;
// starts are taken only when idle and the rate guard has run out
assign start_taken = start_request && converter_on && (state == ST_IDLE) &&
    (guard == 8'h00);
// pin edge history, and start spacing that keeps the rate at or below 100 ksps
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        start_pin_prev <= 1'b0;
        guard <= 8'h00;
    end
    else if (clk_en)
    begin
        start_pin_prev <= external_start_pin;
        if (start_taken)
            guard <= GUARD_LAST;
        else if (guard != 8'h00)
            guard <= guard - 8'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// conversion sequencer
reg [2:0] next_state;
reg sar_load;
always @*
begin
    next_state = state;
    sar_load = 1'b0;
    case (state)
        ST_IDLE:
        begin
            if (start_taken)
            begin
                if (ctl_low_power && (start_source != `SACC_SRC_EXTERNAL))
                    next_state = ST_TRACK;
                else
                begin
                    next_state = ST_CONVERT;
                    sar_load = 1'b1;
                end
            end
        end
        ST_TRACK:
        begin
            if (div_tick && (track_count == `SACC_TRACK_TICKS - 2'd1))
            begin
                next_state = ST_CONVERT;
                sar_load = 1'b1;
            end
        end
        ST_CONVERT:
        begin
            if (sar_finish)
                next_state = ST_IDLE;
        end
        default:
            next_state = ST_IDLE;
    endcase
    // shutdown abandons any conversion in flight
    if (!converter_on)
    begin
        next_state = ST_IDLE;
        sar_load = 1'b0;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_IDLE;
        track_count <= 2'd0;
        conversion_busy <= 1'b0;
    end
    else if (clk_en)
    begin
        state <= next_state;
        conversion_busy <= (next_state != ST_IDLE);
        if (state != ST_TRACK)
            track_count <= 2'd0;
        else if (div_tick)
            track_count <= track_count + 2'd1;
    end
end

// done flag: set as busy falls at the end of a conversion, not on shutdown; cleared only by software, set wins
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        conversion_done_flag <= 1'b0;
        conversion_done_irq <= 1'b0;
        result <= 12'h000;
    end
    else if (clk_en)
    begin
        if (converter_on && (state == ST_CONVERT) && sar_finish)
        begin
            conversion_done_flag <= 1'b1;
            conversion_done_irq <= 1'b1;
            result <= sar_decided;
        end
        else if (ctl_write)
        begin
            conversion_done_flag <= pwdata[`SACC_CTL_DONE];
            conversion_done_irq <= pwdata[`SACC_CTL_DONE];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// analog front end controls
reg next_track;
reg [2:0] next_channel;
reg next_diff;
always @*
begin
    next_track = 1'b0;
    if (converter_on && !chip_standby)
    begin
        if (!ctl_low_power)
            next_track = (state != ST_CONVERT);
        else if (start_source == `SACC_SRC_EXTERNAL)
            next_track = (state == ST_IDLE) && !external_start_pin;
        else
            next_track = (state == ST_TRACK);
    end
    // the odd member of a differential pair reads as the pair itself
    next_channel = channel_code_field[2:0];
    next_diff = pair_config[channel_code_field[2:1]] && !channel_code_field[3];
    if (next_diff)
        next_channel = {channel_code_field[2:1], 1'b0};
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        gain_stage_on <= 1'b0;
        track_enable <= 1'b0;
        mux_channel <= 3'b000;
        mux_differential <= 1'b0;
        mux_temp_sensor <= 1'b0;
    end
    else if (clk_en)
    begin
        gain_stage_on <= converter_on;
        track_enable <= next_track;
        mux_channel <= next_channel;
        mux_differential <= next_diff;
        mux_temp_sensor <= channel_code_field[3];
    end
end

////////////////////////////////////////////////////////////////////////////////
// conversion clock and approximation register
sacc_clock_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .restart(start_taken),
    .divider(clock_divider_field),
    .tick(div_tick)
);

sacc_sar_register u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .load(sar_load),
    .step(div_tick && (state == ST_CONVERT)),
    .comparator_high(comparator_high),
    .trial(sar_trial),
    .decided(sar_decided),
    .finish(sar_finish)
);
endmodule // sacc_conversion_control

/* File: dv/sacc_chk.sv */
// port assertions for the conversion control block
`timescale 1ns/1ps
module sacc_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire chip_standby,
    input wire converter_on,
    input wire gain_stage_on,
    input wire track_enable,
    input wire [11:0] sar_trial,
    input wire conversion_busy,
    input wire conversion_done_irq
);
    reg [8:0] gap;
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // clocks since the last conversion start, saturating
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap <= 9'h1ff;
        else if ($rose(conversion_busy))
            gap <= 9'h001;
        else if (gap != 9'h1ff)
            gap <= gap + 9'h001;
    end
    ////////////////////////////////////////////////////////////////////////////////
    off_quiet_a: assert property (
        !converter_on [*2] |-> !conversion_busy && !gain_stage_on && !track_enable)
        else $error("block active while converter is off");
    on_gain_a: assert property (
        converter_on [*2] |-> gain_stage_on)
        else $error("gain stage off while converter is on");
    standby_track_a: assert property (
        chip_standby [*2] |-> !track_enable)
        else $error("tracking during standby");
    done_set_a: assert property (
        $fell(conversion_busy) && converter_on |-> conversion_done_irq)
        else $error("done flag not set as busy fell");
    done_kept_a: assert property (
        conversion_done_irq && !(psel && penable && pwrite && paddr == 8'h00)
        |=> conversion_done_irq)
        else $error("done flag cleared without a write");
    busy_min_a: assert property (
        $rose(conversion_busy) |-> (conversion_busy || !converter_on) [*8])
        else $error("busy dropped too early");
    busy_end_a: assert property (
        $rose(conversion_busy) |-> ##[1:1000] !conversion_busy)
        else $error("conversion never finished");
    rate_gap_a: assert property (
        $rose(conversion_busy) |-> gap >= 9'h0fa)
        else $error("conversions started too close together");
    first_trial_a: assert property (
        $rose(conversion_busy) |-> ##[0:200] sar_trial == 12'h800)
        else $error("first trial is not mid scale");
endmodule // sacc_chk

/* File: dv/sacc_front.sv */
// analog front end model: comparator against a held input level
`timescale 1ns/1ps
module sacc_front (
    input wire [11:0] sar_trial,
    input wire [11:0] level,
    output wire comparator_high
);
    // input at or above the trial level keeps the bit
    assign comparator_high = (level >= sar_trial);
endmodule // sacc_front

/* File: dv/sacc_conversion_control_test.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sacc_conversion_control_test;
    reg pclk, presetn, clk_en, psel, penable, pwrite, t2, t3, pin, standby, err;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd;
    reg [11:0] level;
    reg [3:0] c, p;
    reg [2:0] g;
    reg [7:0] hi;
    wire [31:0] prdata;
    wire pready, pslverr, comp, con, gon, trk, busy, done, mdiff, mtemp;
    wire [2:0] gain, mch;
    wire [11:0] trial;
    int bad_count, n_checks, i, s, n, e;
    sacc_conversion_control dut_u (.pclk, .presetn, .clk_en, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .timer2_overflow(t2),
        .timer3_overflow(t3), .external_start_pin(pin), .chip_standby(standby),
        .comparator_high(comp), .converter_on(con), .gain_stage_on(gon),
        .track_enable(trk), .gain_select(gain), .mux_channel(mch),
        .mux_differential(mdiff), .mux_temp_sensor(mtemp), .sar_trial(trial),
        .conversion_busy(busy), .conversion_done_irq(done));
    sacc_front front_u (.sar_trial(trial), .level(level), .comparator_high(comp));
    initial
    begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function [15:0] just(input [11:0] v, input l);
        just = l ? {v, 4'h0} : {4'h0, v};
    endfunction
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        presetn = 0;
        clk_en = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        {t2, t3, pin, standby} = 0;
        level = 0;
        void'($urandom(32'h1c303010));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 8'h00, 0);
        `CHK("control reset", 32'h0, rd)
        apb(0, 8'h0c, 0);
        `CHK("config reset", 32'hf8, rd)
        apb(0, 8'h08, 0);
        `CHK("pair reset", 32'h0, rd)
        apb(1, 8'h20, 32'h90);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped start", 1'b0, busy)
        $display("reset values done");
        repeat (6)
        begin
            c = $urandom;
            p = $urandom;
            apb(1, 8'h08, {28'h0, p});
            apb(1, 8'h04, {28'h0, c});
            @(posedge pclk);
            `CHK("temp select", c[3], mtemp)
            `CHK("pair mode", !c[3] && p[c[2:1]], mdiff)
            `CHK("mux channel", (!c[3] && p[c[2:1]]) ? {c[2:1], 1'b0} : c[2:0], mch)
            apb(0, 8'h04, 0);
            `CHK("channel read", {28'h0, c}, rd)
        end
        $display("input selector done");
        for (i = 0; i < 4; i++)
        begin
            level <= $urandom;
            g = $urandom;
            e = (12 + 3 * i[1]) * ((i == 0) ? 1 : 2 * (i + 1));
            apb(1, 8'h0c, {24'h0, i[4:0], g});
            `CHK("gain select", g, gain)
            apb(1, 8'h00, {24'h0, 1'b1, i[1], 5'h00, i[0]});
            `CHK("done cleared", 1'b0, done)
            repeat (40) @(posedge pclk);
            apb(1, 8'h00, {24'h0, 1'b1, i[1], 5'h08, i[0]});
            n = 0;
            while (busy === 1'b1 && n < 3000)
            begin
                n++;
                if (n == 2)
                    `CHK("tracking", i[1], trk)
                @(posedge pclk);
            end
            `CHK("busy length", 1'b1, n + 4 >= e && n <= e + 2)
            `CHK("done irq", 1'b1, done)
            apb(0, 8'h00, 0);
            `CHK("done and busy", 2'b10, rd[5:4])
            apb(0, 8'h10, 0);
            hi = rd[7:0];
            apb(0, 8'h14, 0);
            `CHK("result", just(level, i[0]), {hi, rd[7:0]})
            repeat (250) @(posedge pclk);
        end
        $display("software conversions done");
        for (s = 1; s < 4; s++)
        begin
            apb(1, 8'h00, {24'h0, 4'h8, s[1:0], 2'b00});
            repeat (250) @(posedge pclk);
            apb(1, 8'h00, {24'h0, 4'h9, s[1:0], 2'b00});
            `CHK("busy write start", 1'b0, busy)
            t2 <= (s != 3);
            t3 <= (s == 3);
            @(posedge pclk);
            {t2, t3} <= 2'b00;
            repeat (4) @(posedge pclk);
            `CHK("wrong source start", 1'b0, busy)
            t3 <= (s == 1);
            t2 <= (s == 3);
            pin <= (s == 2);
            @(posedge pclk);
            {t2, t3} <= 2'b00;
            repeat (4) @(posedge pclk);
            `CHK("source start", 1'b1, busy)
            repeat (300) @(posedge pclk);
            pin <= 0;
        end
        $display("start sources done");
        apb(1, 8'h00, 32'hc8);
        repeat (250) @(posedge pclk);
        `CHK("track while pin low", 2'b01, {busy, trk})
        pin <= 1;
        repeat (4) @(posedge pclk);
        `CHK("convert on pin rise", 2'b10, {busy, trk})
        repeat (300) @(posedge pclk);
        apb(1, 8'h00, 32'h80);
        repeat (3) @(posedge pclk);
        `CHK("idle tracking", 1'b1, trk)
        standby <= 1;
        repeat (3) @(posedge pclk);
        `CHK("standby tracking", 1'b0, trk)
        standby <= 0;
        apb(1, 8'h00, 32'h00);
        repeat (2) @(posedge pclk);
        `CHK("shutdown", 3'b000, {con, gon, trk})
        $display("tracking and power done");
        wrap_up;
    end
endmodule // sacc_conversion_control_test
bind sacc_conversion_control sacc_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .chip_standby, .converter_on, .gain_stage_on, .track_enable, .sar_trial,
    .conversion_busy, .conversion_done_irq);
